/* File: hdl/synth_tune_regs.svh */
// Constants for the serial tuning controller
`ifndef SYNTH_TUNE_REGS_SVH
`define SYNTH_TUNE_REGS_SVH
`define WORD_BITS        22
`define DATA_BITS        18
`define ADDR_BITS        4
`define ADDR_MAIN        4'h0
`define ADDR_PWDN        4'h2
`define ADDR_RF_A_N      4'h3
`define ADDR_RF_B_N      4'h4
`define ADDR_IF_N        4'h5
`define PWDN_RF_BIT      0
`define PWDN_IF_BIT      1
`define MAIN_MON_LSB     2
`define MON_SEL_W        3
`define MON_SEL_LOCK     3'h3
`define IF_SEL_W         2
`define IF_SEL_1070      2'h0
`define IF_SEL_1080      2'h1
`define IF_SEL_1089      2'h2
`define UPDATE_NS        5000
`define REF_PERIOD_NS    8
`define TUNE_PERIODS_X2  13
`endif

/* File: hdl/synth_tune_pkg.sv */
// Types for the serial tuning controller
package synth_tune_pkg;
    typedef enum logic [2:0] {
        TUNE_IDLE = 3'b001,
        TUNE_RUN  = 3'b010,
        TUNE_LOCK = 3'b100
    } tune_state_t;
    typedef enum logic [1:0] {
        RF_SRC_A = 2'b01,
        RF_SRC_B = 2'b10
    } rf_src_t;
endpackage

/* File: hdl/serial_word_shifter.sv */
// Serial shift register on the link clock, word latched on enable rise
`timescale 1ns/1ps
`include "synth_tune_regs.svh"
module serial_word_shifter #(
    parameter int WORD_W = `WORD_BITS
) (
    input  wire logic              serial_clk_i,
    input  wire logic              serial_latch_enable_n_i,
    input  wire logic              serial_data_in_i,
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    output logic [WORD_W-1:0]      word_o,
    output logic                   word_valid_o
);
    // Decode in the main file assumes the fixed word layout
    if (WORD_W != `WORD_BITS) begin : g_bad_width
        $error("Word width must be 22");
    end
    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] hold_q;
    logic [2:0]        en_sync_q;
    // Shift only while enabled; older leading bits fall off the top
    always_ff @(posedge serial_clk_i) begin
        if (!serial_latch_enable_n_i) begin
            shift_q <= {shift_q[WORD_W-2:0], serial_data_in_i}; // R2 R4 R5
        end
    end
    // Snapshot on every shift edge; stable once the clock stops before enable rises
    always_ff @(posedge serial_clk_i) begin
        if (!serial_latch_enable_n_i) begin
            hold_q <= {shift_q[WORD_W-2:0], serial_data_in_i};
        end
    end
    // Enable level crosses by two flops; its rise marks the latch
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            en_sync_q <= 3'h7;
        end else begin
            en_sync_q <= {en_sync_q[1:0], serial_latch_enable_n_i};
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            word_valid_o <= 1'b0;
            word_o       <= '0;
        end else begin
            word_valid_o <= en_sync_q[1] & ~en_sync_q[2]; // R3
            if (en_sync_q[1] & ~en_sync_q[2]) begin
                word_o <= hold_q;
            end
        end
    end
endmodule

/* File: hdl/synth_serial_tune_ctrl.sv */
// Tuning sequencer and register file of the triple-PLL synthesizer
`timescale 1ns/1ps
`include "synth_tune_regs.svh"
// Operation
// R1 - Word is 18 data plus 4 address bits
// R2 - Shift data on clock rise while enabled
// R3 - Enable rise writes data to addressed register
// R4 - Enable high freezes the shift register
// R5 - Only last 22 shifted bits are decoded
// R6 - Power-up or new frequency starts self-tuning
// R7 - Only one RF PLL active at once
// R8 - IF offers three fixed frequency settings
// R9 - Lock flag low after tuning, high near limit
// R10 - Lock flag high while any PLL tunes
// R11 - Host re-tunes both PLLs on flag rise; the bench host re-tunes only the RF PLL, and only after the RF limit
// R12 - Host watches flag on monitor output
// R13 - Monitor select 011 routes lock flag out
// R14 - RF divider write selects that RF PLL
// R15 - Data first MSB first, address last
module synth_serial_tune_ctrl #(
    parameter int TUNE_CYCLES = (`UPDATE_NS * `TUNE_PERIODS_X2)
                                / (2 * `REF_PERIOD_NS)
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  serial_clk_i,
    input  wire logic                  serial_latch_enable_n_i,
    input  wire logic                  serial_data_in_i,
    input  wire logic                  power_down_pin_n_i,
    input  wire logic                  if_near_limit_i,
    input  wire logic                  rf_near_limit_i,
    input  wire logic                  aux_signal_i,
    output logic                       lock_detect_n_o,
    output logic                       monitor_output_pin_o,
    output logic                       rf_band_a_en_o,
    output logic                       rf_band_b_en_o,
    output logic                       if_en_o,
    output logic                       if_tuning_o,
    output logic                       rf_tuning_o,
    output logic [`IF_SEL_W-1:0]       if_freq_sel_o,
    output logic [`DATA_BITS-1:0]      rf_n_o
);
    if (TUNE_CYCLES < 1) begin : g_bad_tune
        $error("Tune count must be at least one");
    end
    localparam int CW = $clog2(TUNE_CYCLES + 1);

    logic [`WORD_BITS-1:0]   word;
    logic                    word_valid;
    logic [`DATA_BITS-1:0]   data_f;
    logic [`ADDR_BITS-1:0]   addr_f;
    logic [`MON_SEL_W-1:0]   mon_sel_q;
    logic                    pd_if_q;
    logic                    pd_rf_q;
    logic [`DATA_BITS-1:0]   rf_a_n_q;
    logic [`DATA_BITS-1:0]   rf_b_n_q;
    logic [`IF_SEL_W-1:0]    if_sel_q;
    synth_tune_pkg::rf_src_t rf_src_q;
    logic [1:0]              pwr_sync_q;
    logic [1:0]              lim_if_q;
    logic [1:0]              lim_rf_q;
    logic                    if_on_q;
    logic                    rf_on_q;
    logic                    if_start;
    logic                    rf_start;
    logic                    if_busy;
    logic                    rf_busy;
    logic                    if_done;
    logic                    rf_done;
    logic                    ld_n_d;

    serial_word_shifter #(
        .WORD_W (`WORD_BITS)
    ) u_shift (
        .serial_clk_i            (serial_clk_i),
        .serial_latch_enable_n_i (serial_latch_enable_n_i),
        .serial_data_in_i        (serial_data_in_i),
        .ref_clk_i               (ref_clk_i),
        .rstn_i                  (rstn_i),
        .word_o                  (word),
        .word_valid_o            (word_valid)
    );

    // Address arrives last, so it sits in the low bits
    assign addr_f = word[`ADDR_BITS-1:0]; // R1 R15
    assign data_f = word[`WORD_BITS-1:`ADDR_BITS]; // R1 R15

    function automatic logic hit(input logic [`ADDR_BITS-1:0] a);
        hit = word_valid && (addr_f == a);
    endfunction

    // Pins from outside: two flops before use
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pwr_sync_q <= 2'h0;
            lim_if_q   <= 2'h0;
            lim_rf_q   <= 2'h0;
        end else begin
            pwr_sync_q <= {pwr_sync_q[0], power_down_pin_n_i};
            lim_if_q   <= {lim_if_q[0], if_near_limit_i};
            lim_rf_q   <= {lim_rf_q[0], rf_near_limit_i};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            mon_sel_q <= '0;
        end else if (hit(`ADDR_MAIN)) begin
            mon_sel_q <= data_f[`MAIN_MON_LSB +: `MON_SEL_W]; // R3
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pd_if_q <= 1'b0;
            pd_rf_q <= 1'b0;
        end else if (hit(`ADDR_PWDN)) begin
            pd_if_q <= data_f[`PWDN_IF_BIT]; // R3
            pd_rf_q <= data_f[`PWDN_RF_BIT];
        end
    end

    // Last RF divider written picks the shared output source
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rf_a_n_q <= '0;
            rf_b_n_q <= '0;
            rf_src_q <= synth_tune_pkg::RF_SRC_A;
        end else if (hit(`ADDR_RF_A_N)) begin
            rf_a_n_q <= data_f;
            rf_src_q <= synth_tune_pkg::RF_SRC_A; // R14
        end else if (hit(`ADDR_RF_B_N)) begin
            rf_b_n_q <= data_f;
            rf_src_q <= synth_tune_pkg::RF_SRC_B; // R14
        end
    end

    // Unknown IF codes are ignored, keeping the three legal settings
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            if_sel_q <= `IF_SEL_1080;
        end else if (hit(`ADDR_IF_N)) begin
            case (data_f[`IF_SEL_W-1:0])
                `IF_SEL_1070: if_sel_q <= `IF_SEL_1070; // R8
                `IF_SEL_1080: if_sel_q <= `IF_SEL_1080; // R8
                `IF_SEL_1089: if_sel_q <= `IF_SEL_1089; // R8
                default:      if_sel_q <= if_sel_q;
            endcase
        end
    end

    // Power state: pin low forces everything off
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            if_on_q <= 1'b0;
            rf_on_q <= 1'b0;
        end else begin
            if_on_q <= pwr_sync_q[1] & pd_if_q;
            rf_on_q <= pwr_sync_q[1] & pd_rf_q;
        end
    end

    // Start on power rise, or a new frequency to a powered PLL
    assign if_start = (pwr_sync_q[1] & pd_if_q & ~if_on_q)
                    | (if_on_q & hit(`ADDR_IF_N)); // R6
    assign rf_start = (pwr_sync_q[1] & pd_rf_q & ~rf_on_q)
                    | (rf_on_q & (hit(`ADDR_RF_A_N) | hit(`ADDR_RF_B_N))); // R6

    tune_seq #(.CYCLES(TUNE_CYCLES), .CW(CW)) u_if_seq (
        .clk_i   (ref_clk_i),
        .rstn_i  (rstn_i),
        .start_i (if_start),
        .on_i    (if_on_q),
        .busy_o  (if_busy),
        .done_o  (if_done)
    );
    tune_seq #(.CYCLES(TUNE_CYCLES), .CW(CW)) u_rf_seq (
        .clk_i   (ref_clk_i),
        .rstn_i  (rstn_i),
        .start_i (rf_start),
        .on_i    (rf_on_q),
        .busy_o  (rf_busy),
        .done_o  (rf_done)
    );

    // Flag low only when every running PLL has tuned and none is near its limit
    always_comb begin
        ld_n_d = 1'b1;
        if (if_busy || rf_busy) begin
            ld_n_d = 1'b1; // R10
        end else if (lim_if_q[1] || lim_rf_q[1]) begin
            ld_n_d = 1'b1; // R9
        end else if ((if_done || !if_on_q) && (rf_done || !rf_on_q)
                     && (if_on_q || rf_on_q)) begin
            ld_n_d = 1'b0; // R9
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            lock_detect_n_o      <= 1'b1;
            monitor_output_pin_o <= 1'b0;
        end else begin
            lock_detect_n_o <= ld_n_d;
            if (mon_sel_q == `MON_SEL_LOCK) begin
                monitor_output_pin_o <= ld_n_d; // R13 R12
            end else begin
                monitor_output_pin_o <= aux_signal_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rf_band_a_en_o <= 1'b0;
            rf_band_b_en_o <= 1'b0;
            if_en_o        <= 1'b0;
            if_tuning_o    <= 1'b0;
            rf_tuning_o    <= 1'b0;
            if_freq_sel_o  <= `IF_SEL_1080;
            rf_n_o         <= '0;
        end else begin
            rf_band_a_en_o <= rf_on_q & (rf_src_q == synth_tune_pkg::RF_SRC_A); // R7
            rf_band_b_en_o <= rf_on_q & (rf_src_q == synth_tune_pkg::RF_SRC_B); // R7
            if_en_o        <= if_on_q;
            if_tuning_o    <= if_busy;
            rf_tuning_o    <= rf_busy;
            if_freq_sel_o  <= if_sel_q;
            rf_n_o         <= (rf_src_q == synth_tune_pkg::RF_SRC_B) ? rf_b_n_q : rf_a_n_q;
        end
    end
endmodule

// Per-PLL self-tuning timer
module tune_seq #(
    parameter int CYCLES = 1,
    parameter int CW     = 1
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic start_i,
    input  wire logic on_i,
    output logic      busy_o,
    output logic      done_o
);
    // The down-counter must hold the full count
    if (CYCLES < 1 || CYCLES > (1 << CW)) begin : g_bad_count
        $error("Tune count does not fit the counter");
    end
    synth_tune_pkg::tune_state_t st_q;
    logic [CW-1:0]               cnt_q;
    assign busy_o = (st_q == synth_tune_pkg::TUNE_RUN);
    assign done_o = (st_q == synth_tune_pkg::TUNE_LOCK);
    // A restart mid-tune begins the full count again
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_q  <= synth_tune_pkg::TUNE_IDLE;
            cnt_q <= '0;
        end else if (start_i) begin
            st_q  <= synth_tune_pkg::TUNE_RUN; // R6
            cnt_q <= CW'(CYCLES - 1);
        end else if (!on_i) begin
            st_q  <= synth_tune_pkg::TUNE_IDLE;
        end else begin
            case (st_q)
                synth_tune_pkg::TUNE_RUN: begin
                    if (cnt_q == '0) begin
                        st_q <= synth_tune_pkg::TUNE_LOCK;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                synth_tune_pkg::TUNE_LOCK: st_q <= synth_tune_pkg::TUNE_LOCK;
                synth_tune_pkg::TUNE_IDLE: st_q <= synth_tune_pkg::TUNE_IDLE;
                default:                   st_q <= synth_tune_pkg::TUNE_IDLE;
            endcase
        end
    end
endmodule

/* File: testbench/serial_host_model.sv */
// Host model that clocks configuration words into the controller
`timescale 1ns/1ps
module serial_host_model (
    output logic serial_clk_o,
    output logic serial_latch_enable_n_o,
    output logic serial_data_in_o
);
    initial begin
        serial_clk_o = 1'b0;
        serial_latch_enable_n_o = 1'b1;
        serial_data_in_o = 1'b0;
    end
    // Data moves only while the shift clock is low
    task automatic bit_out(input logic b);
        serial_data_in_o = b;
        #7.5 serial_clk_o = 1'b1;
        #7.5 serial_clk_o = 1'b0;
    endtask
    // Clock stands still outside a word; data idles at the inverse of the last bit
    task automatic send(input logic [21:0] word, input int lead);
        serial_latch_enable_n_o = 1'b0;
        #7.5;
        for (int i = 0; i < lead; i++) begin
            bit_out(i[0]);
        end
        for (int i = 21; i >= 0; i--) begin
            bit_out(word[i]);
        end
        serial_data_in_o = ~word[0];
        #7.5 serial_latch_enable_n_o = 1'b1;
    endtask
    // Word cut in two, with stray clocks while the enable is high in between
    task automatic send_split(input logic [21:0] word, input int cut);
        serial_latch_enable_n_o = 1'b0;
        #7.5;
        for (int i = 21; i >= cut; i--) begin
            bit_out(word[i]);
        end
        #7.5 serial_latch_enable_n_o = 1'b1;
        #30;
        for (int i = 0; i < 4; i++) begin
            bit_out(1'b0);
        end
        #30 serial_latch_enable_n_o = 1'b0;
        #7.5;
        for (int i = cut - 1; i >= 0; i--) begin
            bit_out(word[i]);
        end
        serial_data_in_o = ~word[0];
        #7.5 serial_latch_enable_n_o = 1'b1;
    endtask
endmodule

/* File: testbench/synth_tune_asserts.sv */
// Concurrent checks on the tuning controller ports
`timescale 1ns/1ps
`include "synth_tune_regs.svh"
module synth_tune_asserts #(
    parameter int TUNE_CYCLES = 20
) (
    input wire logic                  ref_clk_i,
    input wire logic                  rstn_i,
    input wire logic                  if_near_limit_i,
    input wire logic                  rf_near_limit_i,
    input wire logic                  lock_detect_n_o,
    input wire logic                  rf_band_a_en_o,
    input wire logic                  rf_band_b_en_o,
    input wire logic                  if_en_o,
    input wire logic                  if_tuning_o,
    input wire logic                  rf_tuning_o,
    input wire logic [`IF_SEL_W-1:0]  if_freq_sel_o,
    input wire logic [`DATA_BITS-1:0] rf_n_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    int unsigned run_q;
    // Length of the current RF tuning run
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || !rf_tuning_o) begin
            run_q <= 0;
        end else begin
            run_q <= run_q + 1;
        end
    end
    wire rf_on = rf_band_a_en_o || rf_band_b_en_o;
    sequence limit_s; (if_near_limit_i || rf_near_limit_i) [*5]; endsequence
    sequence rf_start_s; ##[0:4] rf_tuning_o; endsequence
    one_rf_a: assert property (!(rf_band_a_en_o && rf_band_b_en_o))
        else $error("both rf bands enabled");
    if_code_a: assert property (if_freq_sel_o != 2'h3)
        else $error("if setting out of range");
    tune_lock_a: assert property ((if_tuning_o || rf_tuning_o) |-> lock_detect_n_o)
        else $error("lock flag low while tuning");
    limit_lock_a: assert property (limit_s |-> lock_detect_n_o)
        else $error("lock flag low near limit");
    lock_fall_a: assert property ($fell(lock_detect_n_o) |-> !if_tuning_o && !rf_tuning_o)
        else $error("lock flag fell during tuning");
    pwr_tune_a: assert property ($rose(if_en_o) |-> ##[0:4] if_tuning_o)
        else $error("if power up without tuning");
    freq_tune_a: assert property ($changed(rf_n_o) && rf_on |-> rf_start_s)
        else $error("rf divider change without tuning");
    tune_len_a: assert property ($fell(rf_tuning_o) && rf_on |-> run_q == TUNE_CYCLES)
        else $error("rf tuning run length wrong");
endmodule

bind synth_serial_tune_ctrl synth_tune_asserts #(.TUNE_CYCLES(TUNE_CYCLES)) u_synth_tune_asserts (
    .ref_clk_i, .rstn_i, .if_near_limit_i, .rf_near_limit_i, .lock_detect_n_o,
    .rf_band_a_en_o, .rf_band_b_en_o, .if_en_o, .if_tuning_o, .rf_tuning_o,
    .if_freq_sel_o, .rf_n_o
);

/* File: testbench/synth_serial_tune_ctrl_test.sv */
// Self-checking bench of the serial tuning controller
`timescale 1ns/1ps
`include "synth_tune_regs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module synth_serial_tune_ctrl_test;
    logic              ref_clk_i = 1'b0;
    logic              rstn_i = 1'b0;
    logic              serial_clk_i, serial_latch_enable_n_i, serial_data_in_i;
    logic              power_down_pin_n_i = 1'b1;
    logic              if_near_limit_i = 1'b0;
    logic              rf_near_limit_i = 1'b0;
    logic              aux_signal_i = 1'b0;
    logic              lock_detect_n_o, monitor_output_pin_o, if_en_o;
    logic              rf_band_a_en_o, rf_band_b_en_o, if_tuning_o, rf_tuning_o;
    logic [1:0]        if_freq_sel_o;
    logic [17:0]       rf_n_o;
    int                failures = 0;
    int                comparisons = 0;
    int                cycles = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    // Short tuning run keeps the bench quick
    synth_serial_tune_ctrl #(.TUNE_CYCLES(20)) u_synth_serial_tune_ctrl (
        .ref_clk_i, .rstn_i, .serial_clk_i, .serial_latch_enable_n_i, .serial_data_in_i,
        .power_down_pin_n_i, .if_near_limit_i, .rf_near_limit_i, .aux_signal_i,
        .lock_detect_n_o, .monitor_output_pin_o, .rf_band_a_en_o, .rf_band_b_en_o,
        .if_en_o, .if_tuning_o, .rf_tuning_o, .if_freq_sel_o, .rf_n_o);
    serial_host_model u_serial_host_model (.serial_clk_o(serial_clk_i),
        .serial_latch_enable_n_o(serial_latch_enable_n_i),
        .serial_data_in_o(serial_data_in_i));
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // Ten cycles covers the synchroniser and write latency
    task automatic wr(input logic [3:0] a, input logic [17:0] d, input int lead);
        u_serial_host_model.send({d, a}, lead);
        cyc(10);
    endtask
    task automatic t_power;
        `CHK("reset lock", 1'b1, lock_detect_n_o)
        `CHK("reset if setting", `IF_SEL_1080, if_freq_sel_o)
        wr(`ADDR_PWDN, 18'h0_0003, 0);
        `CHK("if tuning", 1'b1, if_tuning_o)
        `CHK("rf tuning", 1'b1, rf_tuning_o)
        `CHK("lock while tuning", 1'b1, lock_detect_n_o)
        cyc(30);
        `CHK("if on", 1'b1, if_en_o)
        `CHK("lock after tuning", 1'b0, lock_detect_n_o)
        $display("test power done");
    endtask
    task automatic t_rf;
        wr(`ADDR_RF_A_N, 18'h2_a5c3, 7);
        `CHK("bands after a", 2'b10, {rf_band_a_en_o, rf_band_b_en_o})
        `CHK("divider a", 18'h2_a5c3, rf_n_o)
        `CHK("rf retune", 1'b1, rf_tuning_o)
        cyc(30);
        wr(`ADDR_RF_B_N, 18'h1_5a3c, 0);
        `CHK("bands after b", 2'b01, {rf_band_a_en_o, rf_band_b_en_o})
        `CHK("divider b", 18'h1_5a3c, rf_n_o)
        cyc(30);
        $display("test rf done");
    endtask
    task automatic t_if;
        logic [1:0] code [3] = '{`IF_SEL_1070, `IF_SEL_1080, `IF_SEL_1089};
        for (int k = 0; k < 3; k++) begin
            wr(`ADDR_IF_N, {16'h0000, code[k]}, 0);
            `CHK("if setting", code[k], if_freq_sel_o)
            `CHK("if retune", 1'b1, if_tuning_o)
            cyc(30);
        end
        wr(`ADDR_IF_N, 18'h0_0003, 0);
        `CHK("if code 3 refused", `IF_SEL_1089, if_freq_sel_o)
        wr(4'hf, 18'h3_ffff, 0);
        `CHK("unmapped write", 18'h1_5a3c, rf_n_o)
        $display("test if done");
    endtask
    task automatic t_mon;
        // Other source held opposite to the flag so a wrong select shows
        aux_signal_i = 1'b1;
        wr(`ADDR_MAIN, 18'h0_000c, 0);
        `CHK("monitor lock low", 1'b0, monitor_output_pin_o)
        aux_signal_i = 1'b0;
        rf_near_limit_i = 1'b1;
        cyc(8);
        `CHK("lock near limit", 1'b1, lock_detect_n_o)
        `CHK("monitor lock high", 1'b1, monitor_output_pin_o)
        rf_near_limit_i = 1'b0;
        wr(`ADDR_RF_B_N, 18'h1_0001, 0);
        `CHK("host retune", 1'b1, rf_tuning_o)
        cyc(30);
        `CHK("lock after retune", 1'b0, lock_detect_n_o)
        if_near_limit_i = 1'b1;
        cyc(8);
        `CHK("lock near if limit", 1'b1, lock_detect_n_o)
        `CHK("monitor if limit", 1'b1, monitor_output_pin_o)
        if_near_limit_i = 1'b0;
        wr(`ADDR_MAIN, 18'h0_0000, 0);
        aux_signal_i = 1'b1;
        cyc(4);
        `CHK("monitor other source", 1'b1, monitor_output_pin_o)
        aux_signal_i = 1'b0;
        cyc(4);
        `CHK("monitor other low", 1'b0, monitor_output_pin_o)
        $display("test monitor done");
    endtask
    task automatic t_pin;
        power_down_pin_n_i = 1'b0;
        cyc(6);
        `CHK("pin power down", 1'b0, if_en_o | rf_band_b_en_o)
        power_down_pin_n_i = 1'b1;
        cyc(8);
        `CHK("pin power up tunes", 1'b1, if_tuning_o)
        `CHK("lock high on power up", 1'b1, lock_detect_n_o)
        cyc(30);
        `CHK("lock after pin up", 1'b0, lock_detect_n_o)
        // Bits just before the cut read as an unmapped address
        u_serial_host_model.send_split({18'h2_37a5, `ADDR_RF_A_N}, 11);
        cyc(10);
        `CHK("bands back to a", 2'b10, {rf_band_a_en_o, rf_band_b_en_o})
        `CHK("split word divider", 18'h2_37a5, rf_n_o)
        cyc(30);
        $display("test pin done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        cyc(2);
        rstn_i = 1'b1;
        cyc(3);
        t_power;
        t_rf;
        t_if;
        t_mon;
        t_pin;
        tally_and_finish;
    end
endmodule
